//--- hdl/mmr_pkg.sv
// shared constants and carriers for the midi receive interpreter
package mmr_pkg;
	localparam int VOICES = 16;
	localparam int CLK_MHZ = 250;
	// loss-of-sensing timeout in ms and its cycle count
	localparam int SENSE_MS = 300;
	localparam int SENSE_CYC = SENSE_MS * 1000 * CLK_MHZ;
	localparam int CLK_PER_QN = 24;
	localparam int BEAT_W = 14;
	localparam logic [7:0] ST_NOTE_OFF = 8'h80;
	localparam logic [7:0] ST_NOTE_ON = 8'h90;
	localparam logic [7:0] ST_SYSEX = 8'hf0;
	localparam logic [7:0] ST_SONG_POS = 8'hf2;
	localparam logic [7:0] ST_SONG_SEL = 8'hf3;
	localparam logic [7:0] ST_TUNE = 8'hf6;
	localparam logic [7:0] ST_EOX = 8'hf7;
	localparam logic [7:0] ST_CLOCK = 8'hf8;
	localparam logic [7:0] ST_START = 8'hfa;
	localparam logic [7:0] ST_CONT = 8'hfb;
	localparam logic [7:0] ST_STOP = 8'hfc;
	localparam logic [7:0] ST_SENSE = 8'hfe;
	localparam logic [7:0] ST_RESET = 8'hff;
	localparam logic [1:0] MODE_OMNI_POLY = 2'h0;
	localparam logic [1:0] MODE_OMNI_MONO = 2'h1;
	localparam logic [1:0] MODE_CHAN_POLY = 2'h2;
	localparam logic [1:0] MODE_CHAN_MONO = 2'h3;
	localparam logic [1:0] RESET_MODE = MODE_OMNI_POLY;
	localparam logic [3:0] RESET_CHAN = 4'h0;
	// one voice event toward the voice engine
	typedef struct packed {
		logic on;
		logic [3:0] voice;
		logic [6:0] note;
		logic [6:0] vel;
	} mmr_voice_ev_t;
	typedef enum logic [3:0] {
		PS_IDLE = 4'b0001,
		PS_DATA1 = 4'b0010,
		PS_DATA2 = 4'b0100,
		PS_SYSEX = 4'b1000
	} mmr_state_t;
endpackage

//--- hdl/mmr_receiver.sv
// midi message interpreter: channel filter, voice assignment, real time
module mmr_receiver import mmr_pkg::*; #(
	parameter int SENSE_CYCLES = SENSE_CYC,
	parameter logic [6:0] MAKER_ID = 7'h5a // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	input wire logic [1:0] cfg_mode,
	input wire logic cfg_mode_load,
	input wire logic [3:0] cfg_chan,
	input wire logic [VOICES-1:0] kbd_busy,
	output mmr_voice_ev_t voice_ev,
	output logic voice_ev_valid,
	output logic all_notes_off,
	output logic [1:0] rx_mode,
	output logic [3:0] rx_chan,
	output logic playing,
	output logic [4:0] tick_in_qn,
	output logic [BEAT_W-1:0] song_beat_pointer,
	output logic [6:0] song_number,
	output logic song_select,
	output logic autotune_start,
	output logic sysex_data_valid,
	output logic [6:0] sysex_data,
	output logic sysex_done
);
	// the watchdog compare needs at least two counts to tell idle from loss
	if (SENSE_CYCLES < 2) begin : g_bad_sense
		$error("SENSE_CYCLES too small");
	end
	logic [1:0] rst_sync;
	logic rst_n;
	// two-stage reset release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'h1};
	end
	assign rst_n = rst_sync[1];

	mmr_state_t st;
	logic [7:0] status;
	logic [6:0] d1;
	logic sysex_ours;
	logic sysex_first;
	logic is_rt, is_status;
	logic sys_reset;
	logic [VOICES-1:0] busy;
	logic [6:0] vnote [VOICES];
	logic sense_seen;
	logic [31:0] sense_cnt;
	logic [4:0] next_tick;
	assign is_status = rx_valid && rx_byte[7];
	assign is_rt = is_status && rx_byte[7:3] == 5'h1f;
	assign sys_reset = rx_valid && rx_byte == ST_RESET;

	// message parser; real-time bytes pass through without disturbing it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= PS_IDLE;
			status <= 8'h00;
			d1 <= 7'h00;
			sysex_ours <= 1'h0;
			sysex_first <= 1'h0;
		end else if (rx_valid && !is_rt) begin
			if (rx_byte[7]) begin
				status <= rx_byte;
				sysex_first <= rx_byte == ST_SYSEX;
				sysex_ours <= 1'h0;
				unique case (1'b1)
					rx_byte == ST_SYSEX: st <= PS_SYSEX;
					rx_byte == ST_SONG_POS, rx_byte == ST_SONG_SEL,
					rx_byte[7:4] != 4'hf: st <= PS_DATA1;
					default: st <= PS_IDLE;
				endcase
			end else begin
				unique case (st)
					PS_IDLE: st <= PS_IDLE;
					PS_DATA1: begin
						d1 <= rx_byte[6:0];
						if (status == ST_SONG_SEL || status[7:5] == 3'h6)
							st <= PS_DATA1;
						else
							st <= PS_DATA2;
					end
					PS_DATA2: st <= PS_DATA1; // running status
					PS_SYSEX: begin
						sysex_first <= 1'h0;
						if (sysex_first)
							sysex_ours <= rx_byte[6:0] == MAKER_ID;
					end
				endcase
			end
		end
	end

	// mode and channel; reset to factory defaults
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_mode <= RESET_MODE;
			rx_chan <= RESET_CHAN;
		end else if (sys_reset) begin
			rx_mode <= RESET_MODE;
			rx_chan <= RESET_CHAN;
		end else if (cfg_mode_load) begin
			rx_mode <= cfg_mode;
			rx_chan <= cfg_chan;
		end
	end

	// decoded note message
	logic note_msg, chan_ok, key_on, key_off, omni, mono;
	logic [6:0] vel;
	logic [3:0] mchan;
	assign mchan = status[3:0];
	assign vel = rx_byte[6:0];
	assign omni = rx_mode == MODE_OMNI_POLY || rx_mode == MODE_OMNI_MONO;
	assign mono = rx_mode[0];
	assign chan_ok = omni || mchan == rx_chan;
	assign note_msg = rx_valid && !rx_byte[7] && st == PS_DATA2 && chan_ok
		&& (status[7:4] == ST_NOTE_ON[7:4] || status[7:4] == ST_NOTE_OFF[7:4]);
	assign key_on = note_msg && status[7:4] == ST_NOTE_ON[7:4] && vel != 7'h00;
	assign key_off = note_msg && !key_on;

	// voice choice: first free voice for poly, fixed voice for mono
	logic [3:0] free_v, hit_v, tgt_v;
	logic free_ok, hit_ok;
	always_comb begin
		free_v = 4'h0;
		free_ok = 1'h0;
		hit_v = 4'h0;
		hit_ok = 1'h0;
		for (int i = VOICES - 1; i >= 0; i--) begin
			if (!busy[i] && !kbd_busy[i]) begin
				free_v = 4'(i);
				free_ok = 1'h1;
			end
			if (busy[i] && vnote[i] == d1 && (rx_mode != MODE_CHAN_MONO
				|| 4'(i) == mchan)) begin
				hit_v = 4'(i);
				hit_ok = 1'h1;
			end
		end
	end
	always_comb begin
		unique case (rx_mode)
			MODE_CHAN_MONO: tgt_v = mchan;
			MODE_OMNI_MONO: tgt_v = 4'h0;
			default: tgt_v = free_v;
		endcase
	end

	// voice table and events; sensing loss or reset silences all
	logic kill;
	logic fire_on;
	assign fire_on = key_on && (mono || free_ok);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= '0;
			voice_ev <= '0;
			voice_ev_valid <= 1'h0;
			all_notes_off <= 1'h0;
		end else begin
			voice_ev_valid <= 1'h0;
			all_notes_off <= kill;
			if (kill) begin
				busy <= '0;
			end else if (fire_on) begin
				busy[tgt_v] <= 1'h1;
				voice_ev <= '{1'h1, tgt_v, d1, vel};
				voice_ev_valid <= 1'h1;
			end else if (key_off && hit_ok) begin
				busy[hit_v] <= 1'h0;
				voice_ev <= '{1'h0, hit_v, d1, 7'h00};
				voice_ev_valid <= 1'h1;
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (fire_on && !kill)
			vnote[tgt_v] <= d1;
	end

	// active sensing watchdog, restarted by any byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_seen <= 1'h0;
			sense_cnt <= '0;
		end else if (rx_valid) begin
			sense_cnt <= '0;
			if (rx_byte == ST_SENSE)
				sense_seen <= 1'h1;
			else if (sys_reset)
				sense_seen <= 1'h0;
		end else if (sense_seen) begin
			if (sense_cnt == 32'(SENSE_CYCLES - 1)) begin
				sense_seen <= 1'h0;
				sense_cnt <= '0;
			end else
				sense_cnt <= sense_cnt + 32'h1;
		end
	end
	assign kill = sys_reset || (sense_seen && !rx_valid
		&& sense_cnt == 32'(SENSE_CYCLES - 1));

	// transport: start, stop, continue, clock
	assign next_tick = (tick_in_qn == 5'(CLK_PER_QN - 1)) ? 5'h0
		: tick_in_qn + 5'h1;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			playing <= 1'h0;
			tick_in_qn <= 5'h0;
			song_beat_pointer <= '0;
		end else if (rx_valid) begin
			unique case (rx_byte)
				ST_START: begin
					playing <= 1'h1;
					tick_in_qn <= 5'h0;
					song_beat_pointer <= '0;
				end
				ST_STOP: playing <= 1'h0;
				ST_CONT: playing <= 1'h1;
				ST_RESET: begin
					playing <= 1'h0;
					tick_in_qn <= 5'h0;
					song_beat_pointer <= '0;
				end
				ST_CLOCK: if (playing) begin
					tick_in_qn <= next_tick;
					// one beat is six clocks; pointer wraps at 16384
					if (tick_in_qn == 5'h5 || tick_in_qn == 5'hb
						|| tick_in_qn == 5'h11 || tick_in_qn == 5'h17)
						song_beat_pointer <= song_beat_pointer + 1'b1;
				end
				default: ; // song position is deliberately dropped
			endcase
		end
	end

	// system common and exclusive strobes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			song_number <= 7'h00;
			song_select <= 1'h0;
			autotune_start <= 1'h0;
			sysex_data_valid <= 1'h0;
			sysex_data <= 7'h00;
			sysex_done <= 1'h0;
		end else begin
			song_select <= 1'h0;
			autotune_start <= rx_valid && rx_byte == ST_TUNE;
			sysex_data_valid <= rx_valid && !rx_byte[7] && st == PS_SYSEX
				&& sysex_ours && !sysex_first;
			sysex_done <= rx_valid && rx_byte == ST_EOX
				&& st == PS_SYSEX && sysex_ours;
			if (rx_valid && !rx_byte[7])
				sysex_data <= rx_byte[6:0];
			if (rx_valid && !rx_byte[7] && st == PS_DATA1
				&& status == ST_SONG_SEL) begin
				song_number <= rx_byte[6:0];
				song_select <= 1'h1;
			end
		end
	end

	sequence stop_seen_s;
		rx_valid && rx_byte == ST_STOP;
	endsequence
	stop_holds_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		stop_seen_s |=> !playing && $stable(song_beat_pointer))
		else $error("stop did not halt");
	start_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_valid && rx_byte == ST_START |=> song_beat_pointer == '0
		&& playing)
		else $error("start did not rewind");
	cont_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_valid && rx_byte == ST_CONT && !playing |=> playing
		&& song_beat_pointer == $past(song_beat_pointer))
		else $error("continue lost position");
	tick_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tick_in_qn < 5'(CLK_PER_QN))
		else $error("tick out of range");
	spp_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_valid && rx_byte[7] == 1'b0 && !playing
		|=> $stable(song_beat_pointer))
		else $error("pointer moved on data");
	chan_filter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_valid && !rx_byte[7] && st == PS_DATA2 && !omni && mchan != rx_chan
		|=> !voice_ev_valid)
		else $error("foreign channel accepted");
	vel_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		note_msg && vel == 7'h00 && hit_ok && !kill
		|=> voice_ev_valid && !voice_ev.on)
		else $error("velocity zero not off");
	sense_kill_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		kill |=> all_notes_off && busy == '0)
		else $error("notes not silenced");
	mono_voice_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		voice_ev_valid && voice_ev.on && $past(rx_mode) == MODE_OMNI_MONO
		|-> voice_ev.voice == 4'h0)
		else $error("mono used other voice");
	tune_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rx_valid && rx_byte == ST_TUNE |=> autotune_start)
		else $error("tune request dropped");
endmodule // mmr_receiver

//--- tb/mmr_midi_tx.sv
// midi transmitter model feeding the receiver byte port
module mmr_midi_tx import mmr_pkg::*; (
	input wire logic ref_clk,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	// one byte every two cycles, valid for one cycle, launched off the sampling edge
	task automatic send(input logic [7:0] b);
		@(negedge ref_clk);
		rx_byte = b;
		rx_valid = 1'b1;
		@(negedge ref_clk);
		rx_valid = 1'b0;
		rx_byte = ~b; // stale byte must not look valid
	endtask
	// tempo source: one clock byte per 24th of a quarter
	task automatic clocks(input int n);
		repeat (n) send(ST_CLOCK);
	endtask
	// exclusive frame always closed by end of exclusive
	task automatic sysex(input logic [6:0] id, input logic [6:0] d);
		send(ST_SYSEX);
		send({1'b0, id});
		send({1'b0, d});
		send(ST_EOX);
	endtask
	// keepalive, sent once by the bench to arm the watchdog
	task automatic sense();
		send(ST_SENSE);
	endtask
endmodule // mmr_midi_tx

//--- tb/tb_midi_mode_realtime_receiver.sv
// self-checking bench for the midi receive interpreter
module tb_midi_mode_realtime_receiver import mmr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] OWN_ID = 7'h3c; // arbitrary value
	logic ref_clk, rst_b, cfg_mode_load;
	logic [1:0] cfg_mode;
	logic [3:0] cfg_chan;
	logic [VOICES-1:0] kbd_busy;
	logic [7:0] rx_byte;
	logic rx_valid, voice_ev_valid, all_notes_off, playing, song_select;
	logic autotune_start, sysex_data_valid, sysex_done;
	mmr_voice_ev_t voice_ev, ev_last;
	logic [1:0] rx_mode;
	logic [3:0] rx_chan;
	logic [4:0] tick_in_qn;
	logic [BEAT_W-1:0] song_beat_pointer;
	logic [6:0] song_number, sysex_data, sx_last;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	int ev_n = 0, off_n = 0, tune_n = 0, sel_n = 0, sx_n = 0, done_n = 0;
	mmr_receiver #(.SENSE_CYCLES(50), .MAKER_ID(OWN_ID)) u_dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.cfg_mode(cfg_mode),
		.cfg_mode_load(cfg_mode_load),
		.cfg_chan(cfg_chan),
		.kbd_busy(kbd_busy),
		.voice_ev(voice_ev),
		.voice_ev_valid(voice_ev_valid),
		.all_notes_off(all_notes_off),
		.rx_mode(rx_mode),
		.rx_chan(rx_chan),
		.playing(playing),
		.tick_in_qn(tick_in_qn),
		.song_beat_pointer(song_beat_pointer),
		.song_number(song_number),
		.song_select(song_select),
		.autotune_start(autotune_start),
		.sysex_data_valid(sysex_data_valid),
		.sysex_data(sysex_data),
		.sysex_done(sysex_done)
	);
	mmr_midi_tx u_tx (
		.ref_clk(ref_clk),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid)
	);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// pulse monitor; a hang is cut short by the cycle ceiling
	always @(posedge ref_clk) begin
		cyc++;
		if (voice_ev_valid === 1'b1) begin
			ev_n++;
			ev_last = voice_ev;
		end
		if (all_notes_off === 1'b1) off_n++;
		if (autotune_start === 1'b1) tune_n++;
		if (song_select === 1'b1) sel_n++;
		if (sysex_done === 1'b1) done_n++;
		if (sysex_data_valid === 1'b1) begin
			sx_n++;
			sx_last = sysex_data;
		end
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic settle();
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic note(input logic [7:0] st, nt, vel);
		u_tx.send(st);
		u_tx.send(nt);
		u_tx.send(vel);
		settle();
	endtask
	// exactly one new voice event with these fields
	task automatic ev(input int n0, input logic on, input logic [3:0] vc,
			input logic [6:0] nt);
		chk("ev_count", ev_n, n0 + 1);
		chk("ev_on", ev_last.on, on);
		chk("ev_voice", ev_last.voice, vc);
		chk("ev_note", ev_last.note, nt);
		chk("ev_vel", ev_last.vel, on ? 7'h40 : 7'h00);
	endtask
	task automatic load(input logic [1:0] m, input logic [3:0] c);
		cfg_mode = m;
		cfg_chan = c;
		cfg_mode_load = 1'b1;
		@(negedge ref_clk);
		cfg_mode_load = 1'b0;
		@(negedge ref_clk);
		chk("rx_mode", rx_mode, m);
		chk("rx_chan", rx_chan, c);
	endtask
	// keyboard holds all but voice 0, so the pool runs dry after one note
	task automatic t_poly();
		kbd_busy = 16'hfffe;
		note(8'h95, 8'h3c, 8'h40);
		ev(0, 1'b1, 4'h0, 7'h3c);
		note(8'h9a, 8'h3d, 8'h40);
		chk("ev_full", ev_n, 1);
		note(8'h95, 8'h3c, 8'h00);
		ev(1, 1'b0, 4'h0, 7'h3c);
		kbd_busy = 16'h0000;
		note(8'h9c, 8'h3e, 8'h40);
		ev(2, 1'b1, 4'h0, 7'h3e);
		note(8'h8c, 8'h3e, 8'h40);
		ev(3, 1'b0, 4'h0, 7'h3e);
	endtask
	task automatic t_modes();
		load(MODE_CHAN_POLY, 4'h3);
		note(8'h94, 8'h40, 8'h40);
		chk("ev_other", ev_n, 4);
		note(8'h93, 8'h40, 8'h40);
		ev(4, 1'b1, 4'h0, 7'h40);
		load(MODE_OMNI_MONO, 4'h0);
		note(8'h99, 8'h30, 8'h40);
		ev(5, 1'b1, 4'h0, 7'h30);
		note(8'h92, 8'h31, 8'h40);
		ev(6, 1'b1, 4'h0, 7'h31);
		load(MODE_CHAN_MONO, 4'h7);
		note(8'h97, 8'h32, 8'h40);
		ev(7, 1'b1, 4'h7, 7'h32);
	endtask
	task automatic t_transport();
		chk("beat_w", $bits(song_beat_pointer), 14);
		u_tx.send(ST_START);
		settle();
		chk("play", playing, 1'b1);
		u_tx.clocks(13);
		settle();
		chk("tick", tick_in_qn, 5'd13);
		chk("beat", song_beat_pointer, 2);
		u_tx.clocks(11);
		u_tx.send(ST_STOP);
		u_tx.clocks(3);
		u_tx.send(ST_SONG_POS);
		u_tx.send(8'h10);
		u_tx.send(8'h00);
		settle();
		chk("stopped", playing, 1'b0);
		chk("tick_hold", tick_in_qn, 5'd0);
		chk("beat_hold", song_beat_pointer, 4);
		u_tx.send(ST_CONT);
		u_tx.clocks(6);
		settle();
		chk("resume", playing, 1'b1);
		chk("beat_resume", song_beat_pointer, 5);
		u_tx.send(ST_START);
		settle();
		chk("beat_start", song_beat_pointer, 0);
	endtask
	task automatic t_common();
		u_tx.send(ST_SONG_SEL);
		u_tx.send(8'h2a);
		u_tx.send(ST_TUNE);
		u_tx.sysex(OWN_ID, 7'h11);
		u_tx.sysex(7'h12, 7'h22);
		settle();
		chk("sel", sel_n, 1);
		chk("song", song_number, 7'h2a);
		chk("tune", tune_n, 1);
		chk("sx_n", sx_n, 1);
		chk("sx_data", sx_last, 7'h11);
		chk("sx_done", done_n, 1);
	endtask
	// bytes closer than the timeout keep the watchdog quiet
	task automatic t_sense();
		u_tx.sense();
		repeat (3) begin
			repeat (30) @(negedge ref_clk);
			u_tx.send(ST_CLOCK);
		end
		chk("alive", off_n, 0);
		repeat (70) @(negedge ref_clk);
		chk("lost", off_n, 1);
		load(MODE_CHAN_MONO, 4'h9);
		u_tx.send(ST_RESET);
		settle();
		chk("rst_off", off_n, 2);
		chk("rst_mode", rx_mode, RESET_MODE);
		chk("rst_chan", rx_chan, RESET_CHAN);
		chk("rst_play", playing, 1'b0);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		cfg_mode_load = 1'b0;
		cfg_mode = MODE_OMNI_POLY;
		cfg_chan = RESET_CHAN;
		kbd_busy = '0;
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_poly();
		t_modes();
		t_transport();
		t_common();
		t_sense();
		complete_run();
	end
endmodule // tb_midi_mode_realtime_receiver
